//--- design/acis_pkg.sv
package acis_pkg;
   localparam logic [31:0] ACIS_SELECT_OFFSET = 32'h0000_0000;
   localparam logic [31:0] ACIS_MODE_OFFSET = 32'h0000_0004;
   localparam logic [31:0] ACIS_ROUTE_OFFSET = 32'h0000_0008;
   localparam int ACIS_SA_BIT = 0;
   localparam int ACIS_NA_LSB = 1;
   localparam int ACIS_SB_BIT = 8;
   localparam int ACIS_NB_LSB = 9;
   localparam logic [15:0] ACIS_SELECT_RESET = 16'h0000;
   localparam logic [15:0] ACIS_SELECT_MASK = 16'h0707;
   // Analog source codes driven onto each channel's mux.
   typedef enum logic [3:0] {
      ACIS_SRC_LOW_REF = 4'h0,
      ACIS_SRC_IN0 = 4'h1,
      ACIS_SRC_IN1 = 4'h2,
      ACIS_SRC_IN2 = 4'h3,
      ACIS_SRC_IN3 = 4'h4,
      ACIS_SRC_IN6 = 4'h5,
      ACIS_SRC_IN7 = 4'h6,
      ACIS_SRC_IN8 = 4'h7,
      ACIS_SRC_IN9 = 4'h8,
      ACIS_SRC_IN10 = 4'h9,
      ACIS_SRC_IN11 = 4'hA,
      ACIS_SRC_AMP1 = 4'hB,
      ACIS_SRC_AMP2 = 4'hC,
      ACIS_SRC_AMP3 = 4'hD
   } acis_src_type;
endpackage : acis_pkg

//--- design/acis_route.sv
`timescale 1ns/100ps
// Turns a positive and negative select into per-channel source codes.
module acis_route
   import acis_pkg::*;
(
   input wire logic pos_sel,
   input wire logic [1:0] neg_sel,
   input wire logic [2:0] opamp_enable,
   output acis_src_type pos_src [3],
   output acis_src_type neg_src [3]
);
   always_comb begin
      if (pos_sel) begin
         pos_src[0] = opamp_enable[0] ? ACIS_SRC_AMP1 : ACIS_SRC_IN3;
         pos_src[1] = opamp_enable[1] ? ACIS_SRC_AMP2 : ACIS_SRC_IN0;
         pos_src[2] = opamp_enable[2] ? ACIS_SRC_AMP3 : ACIS_SRC_IN6;
      end else begin
         pos_src[0] = opamp_enable[1] ? ACIS_SRC_AMP2 : ACIS_SRC_IN0;
         pos_src[1] = ACIS_SRC_IN1;
         pos_src[2] = ACIS_SRC_IN2;
      end
      unique casez (neg_sel)
         2'b11: begin
            neg_src[0] = ACIS_SRC_IN9;
            neg_src[1] = ACIS_SRC_IN10;
            neg_src[2] = ACIS_SRC_IN11;
         end
         2'b10: begin
            neg_src[0] = opamp_enable[2] ? ACIS_SRC_AMP3 : ACIS_SRC_IN6;
            neg_src[1] = ACIS_SRC_IN7;
            neg_src[2] = ACIS_SRC_IN8;
         end
         2'b0?: begin
            neg_src[0] = ACIS_SRC_LOW_REF;
            neg_src[1] = ACIS_SRC_LOW_REF;
            neg_src[2] = ACIS_SRC_LOW_REF;
         end
      endcase
   end
endmodule : acis_route

//--- design/acis_top.sv
`timescale 1ns/100ps
// Behaviour
// - MUXB negative field 11 picks inputs 9-11, 10 picks 6-8, 0x low reference.
// - In twelve-bit mode the MUXB negative field reads zero and a write clears it.
// - MUXB positive bit 1 picks op-amp 1/2/3 set, 0 picks 0/1/2 set.
// - In twelve-bit mode the MUXB positive bit reads zero and a write clears it.
// - Bits 2:1 hold the MUXA negative select for channels 1 to 3.
// - In twelve-bit mode the MUXA negative field reads zero and a write clears it.
// - Bits 15:11 read zero and ignore writes.
// - Bits 7:3 read zero and ignore writes.
// - An op-amp output is routed only when that op-amp is enabled.
module acis_top
   import acis_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic sample_set_b,
   output acis_src_type pos_src [3],
   output acis_src_type neg_src [3]
);
   logic wr_pend_r;
   logic [31:0] wr_addr_r;
   logic [15:0] select_r;
   logic twelve_bit_mode_flag_r;
   logic [2:0] opamp_enable_r;
   logic [15:0] select_view;
   logic [31:0] rd_nxt;
   logic pos_sel;
   logic [1:0] neg_sel;

   // Register decode shared by the read and write paths.
   function automatic logic [1:0] acis_decode(input logic [31:0] a);
      if (a == ACIS_SELECT_OFFSET) begin
         acis_decode = 2'h1;
      end else if (a == ACIS_MODE_OFFSET) begin
         acis_decode = 2'h2;
      end else if (a == ACIS_ROUTE_OFFSET) begin
         acis_decode = 2'h3;
      end else begin
         acis_decode = 2'h0;
      end
   endfunction : acis_decode

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Twelve-bit mode hides every field except the MUXA positive bit.
   always_comb begin
      select_view = select_r & ACIS_SELECT_MASK;
      if (twelve_bit_mode_flag_r) begin
         select_view[ACIS_NB_LSB +: 2] = 2'h0;
         select_view[ACIS_SB_BIT] = 1'b0;
         select_view[ACIS_NA_LSB +: 2] = 2'h0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 32'h0000_0000;
      end else if (hready) begin
         wr_pend_r <= hsel && htrans[1] && hwrite;
         wr_addr_r <= haddr;
      end
   end

   // In twelve-bit mode a write keeps only the MUXA positive bit and clears the hidden fields to zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         select_r <= ACIS_SELECT_RESET;
      end else if (wr_pend_r && acis_decode(wr_addr_r) == 2'h1) begin
         if (twelve_bit_mode_flag_r) begin
            select_r <= {15'h0000, hwdata[ACIS_SA_BIT]};
         end else begin
            select_r <= hwdata[15:0] & ACIS_SELECT_MASK;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         twelve_bit_mode_flag_r <= 1'b0;
         opamp_enable_r <= 3'h0;
      end else if (wr_pend_r) begin
         if (acis_decode(wr_addr_r) == 2'h2) begin
            twelve_bit_mode_flag_r <= hwdata[0];
         end
         if (acis_decode(wr_addr_r) == 2'h3) begin
            opamp_enable_r <= hwdata[2:0];
         end
      end
   end

   always_comb begin
      unique case (acis_decode(haddr))
         2'h1: rd_nxt = {16'h0000, select_view};
         2'h2: rd_nxt = {31'h0000_0000, twelve_bit_mode_flag_r};
         2'h3: rd_nxt = {29'h0000_0000, opamp_enable_r};
         2'h0: rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata <= rd_nxt;
      end
   end

   assign pos_sel = sample_set_b ? select_view[ACIS_SB_BIT] : select_view[ACIS_SA_BIT];
   assign neg_sel = sample_set_b ? select_view[ACIS_NB_LSB +: 2] : select_view[ACIS_NA_LSB +: 2];

   acis_route u_route (
      .pos_sel(pos_sel),
      .neg_sel(neg_sel),
      .opamp_enable(opamp_enable_r),
      .pos_src(pos_src),
      .neg_src(neg_src)
   );
endmodule : acis_top

//--- test/acis_chk.sv
`timescale 1ns/100ps
module acis_chk
   import acis_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire acis_src_type pos_src [3],
   input wire acis_src_type neg_src [3]
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_ok; hreadyout && !hresp; endproperty
   a_ok: assert property (p_ok) else $error("bus stalled");
   property p_hi; hrdata[15:11] == 5'h0; endproperty
   a_hi: assert property (p_hi) else $error("high bits set");
   property p_lo; hrdata[7:3] == 5'h0; endproperty
   a_lo: assert property (p_lo) else $error("mid bits set");
   property p_nb; neg_src[0] == ACIS_SRC_IN9 |-> neg_src[2] == ACIS_SRC_IN11; endproperty
   a_nb: assert property (p_nb) else $error("neg set split");
   property p_rf; neg_src[0] == ACIS_SRC_LOW_REF |-> neg_src[1] == ACIS_SRC_LOW_REF; endproperty
   a_rf: assert property (p_rf) else $error("ref split");
   property p_sb; pos_src[2] == ACIS_SRC_IN2 |-> pos_src[1] == ACIS_SRC_IN1; endproperty
   a_sb: assert property (p_sb) else $error("pos set split");
   property p_oa;
      neg_src[1] == ACIS_SRC_IN7 |-> neg_src[0] inside {ACIS_SRC_IN6, ACIS_SRC_AMP3};
   endproperty
   a_oa: assert property (p_oa) else $error("op-amp pick");
   property p_rs; $rose(hresetn) |-> pos_src[0] == ACIS_SRC_IN0 && hrdata == '0; endproperty
   a_rs: assert property (p_rs) else $error("reset state");
endmodule : acis_chk
bind acis_top acis_chk chk (.hclk, .hresetn, .hreadyout, .hresp, .hrdata, .pos_src, .neg_src);

//--- test/acis_top_bench.sv
`timescale 1ns/100ps
module acis_top_bench
   import acis_pkg::*;
;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sample_set_b = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0] htrans = '0;
   logic hreadyout, hresp;
   acis_src_type pos_src [3], neg_src [3];
   int fails = 0, checked = 0;
   acis_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sample_set_b, .pos_src, .neg_src);
   initial begin
      forever #20 hclk = ~hclk;
   end
   task cmp(input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task xfer(input logic w, input logic [31:0] a, d);
      @(posedge hclk);
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
   endtask : xfer
   task rd(input logic [31:0] a, e);
      xfer(1'h0, a, '0);
      cmp(hrdata, e);
   endtask : rd
   // Sources are combinational, so they are sampled half a cycle after the select moves.
   task sc(input logic b, input logic [23:0] e);
      @(posedge hclk);
      sample_set_b <= b;
      @(negedge hclk);
      cmp({pos_src[0], pos_src[1], pos_src[2], neg_src[0], neg_src[1], neg_src[2]}, e);
   endtask : sc
   task close_out;
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   initial begin
      #40000;
      fails++;
      close_out;
   end
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'h1;
      rd(32'h0, 32'h0);
      rd(32'h8, 32'h0);
      sc(1'h0, 24'h12_3000);
      xfer(1'h1, 32'h0, 32'hFFFF_FFFF);
      rd(32'h0, 32'h0707);
      sc(1'h1, 24'h41_589A);
      sc(1'h0, 24'h41_589A);
      xfer(1'h1, 32'h8, 32'h7);
      sc(1'h1, 24'hBC_D89A);
      xfer(1'h1, 32'h0, 32'h0400);
      sc(1'h1, 24'hC2_3D67);
      sc(1'h0, 24'hC2_3000);
      xfer(1'h1, 32'h8, 32'h3);
      sc(1'h1, 24'hC2_3567);
      xfer(1'h1, 32'h0, 32'h0707);
      xfer(1'h1, 32'h4, 32'h1);
      rd(32'h0, 32'h1);
      sc(1'h1, 24'hC2_3000);
      sc(1'h0, 24'hBC_5000);
      xfer(1'h1, 32'h0, 32'hFFFF_FFFE);
      xfer(1'h1, 32'h4, 32'h0);
      rd(32'h0, 32'h0);
      xfer(1'h1, 32'hC, 32'h5);
      rd(32'hC, 32'h0);
      rd(32'h8, 32'h3);
      close_out;
   end
endmodule : acis_top_bench
